//--- hdl/system_reset_controller.sv
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Reset pin low 768 RC ticks resets
// - Five hardware sources each reset the chip
// - Every reset sets its own readable cause flag
// - Software requests system, core and chip resets
// - Chip one-shot request clears itself after issue
// - Boot select survives system and core resets
module system_reset_controller (
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             resetn_i,
  // Hardware reset sources, active high levels except the active-low external reset pin; RC tick for the pin filter
  input  wire logic                             power_on_detect_i,
  input  wire logic                             external_reset_input_i,
  input  wire logic                             rc_tick_i,
  input  wire logic                             watchdog_timeout_i,
  input  wire logic                             low_voltage_detect_i,
  input  wire logic                             brownout_detect_i,
  // Software requests
  input  wire logic                             system_reset_request_i,
  input  wire logic                             chip_reset_control_wr_i,
  input  wire logic [rst_ctrl_pkg::CTRL_W-1:0]  chip_reset_control_wdata_i,
  input  wire logic                             reset_cause_clr_i,
  input  wire logic [rst_ctrl_pkg::CAUSE_W-1:0] reset_cause_clr_mask_i,
  input  wire logic                             boot_source_select_wr_i,
  input  wire logic                             boot_source_select_wdata_i,
  // Reset outputs, active high
  output logic                                  chip_reset_o,
  output logic                                  system_reset_o,
  output logic                                  core_reset_o,
  // Status
  output logic [rst_ctrl_pkg::CAUSE_W-1:0]      reset_cause_flags_o,
  output logic [rst_ctrl_pkg::CTRL_W-1:0]       chip_reset_control_o,
  output logic                                  boot_source_select_o
);

  logic                                rst_meta_q;
  logic                                rst_n;
  logic                                pin_reset;
  logic [4:0]                          hw_lvl;
  logic [4:0]                          hw_prev_q;
  logic [4:0]                          hw_rise;
  logic                                hw_active;
  logic                                sys_pend_q;
  logic [rst_ctrl_pkg::CTRL_W-1:0]     ctrl_q;
  rst_ctrl_pkg::seq_state_e            state_q;
  rst_ctrl_pkg::seq_state_e            state_d;
  rst_ctrl_pkg::scope_e                scope_q;
  rst_ctrl_pkg::scope_e                scope_d;
  logic [rst_ctrl_pkg::PULSE_CNT_W-1:0] cnt_q;
  logic [rst_ctrl_pkg::PULSE_CNT_W-1:0] cnt_d;
  logic                                start_chip;
  logic                                start_sys;
  logic                                start_core;
  logic [rst_ctrl_pkg::CAUSE_W-1:0]    cause_set;

  // Chip scope about to be held; shared by chip_reset_o and the boot select
  function automatic logic chip_hold(input rst_ctrl_pkg::seq_state_e st, input rst_ctrl_pkg::scope_e sc);
    return (st == rst_ctrl_pkg::ST_HOLD) && (sc == rst_ctrl_pkg::SCOPE_CHIP);
  endfunction

  // Reset release through two flip-flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  reset_pin_filter u_pin_filter (
    .clk_i       (clk_i),
    .rst_ni      (rst_n),
    .rc_tick_i   (rc_tick_i),
    .pin_i       (external_reset_input_i),
    .pin_reset_o (pin_reset)
  );

  assign hw_lvl    = {brownout_detect_i, low_voltage_detect_i, watchdog_timeout_i, pin_reset, power_on_detect_i};
  assign hw_active = |hw_lvl;
  assign hw_rise   = hw_lvl & ~hw_prev_q;

  // Edge memory for per-source cause detection
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hw_prev_q <= '0;
    end else begin
      hw_prev_q <= hw_lvl;
    end
  end

  // latch system request
  // A request arriving during another reset is kept until it is served or a chip reset starts
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sys_pend_q <= 1'b0;
    end else if (system_reset_request_i) begin
      sys_pend_q <= 1'b1;
    end else if (start_sys || start_chip) begin
      sys_pend_q <= 1'b0;
    end
  end

  // self-clearing one-shots
  // Bits drop when their pulse starts; a chip reset swallows a pending core request
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= rst_ctrl_pkg::CTRL_RESET;
    end else begin
      ctrl_q[rst_ctrl_pkg::CTRL_CHIP_BIT] <= (ctrl_q[rst_ctrl_pkg::CTRL_CHIP_BIT] && !start_chip)
          || (chip_reset_control_wr_i && chip_reset_control_wdata_i[rst_ctrl_pkg::CTRL_CHIP_BIT]);
      ctrl_q[rst_ctrl_pkg::CTRL_CORE_BIT] <= (ctrl_q[rst_ctrl_pkg::CTRL_CORE_BIT] && !start_core && !start_chip)
          || (chip_reset_control_wr_i && chip_reset_control_wdata_i[rst_ctrl_pkg::CTRL_CORE_BIT]);
    end
  end

  // prioritise reset scopes
  // Chip scope wins over system, system over core; hardware sources extend the hold
  always_comb begin
    state_d    = state_q;
    scope_d    = scope_q;
    cnt_d      = cnt_q;
    start_chip = 1'b0;
    start_sys  = 1'b0;
    start_core = 1'b0;
    case (state_q)
      rst_ctrl_pkg::ST_IDLE: begin
        if (hw_active || ctrl_q[rst_ctrl_pkg::CTRL_CHIP_BIT]) begin
          start_chip = 1'b1;
          state_d    = rst_ctrl_pkg::ST_HOLD;
          scope_d    = rst_ctrl_pkg::SCOPE_CHIP;
          cnt_d      = rst_ctrl_pkg::PULSE_CNT_LOAD;
        end else if (sys_pend_q) begin
          start_sys = 1'b1;
          state_d   = rst_ctrl_pkg::ST_HOLD;
          scope_d   = rst_ctrl_pkg::SCOPE_SYS;
          cnt_d     = rst_ctrl_pkg::PULSE_CNT_LOAD;
        end else if (ctrl_q[rst_ctrl_pkg::CTRL_CORE_BIT]) begin
          start_core = 1'b1;
          state_d    = rst_ctrl_pkg::ST_HOLD;
          scope_d    = rst_ctrl_pkg::SCOPE_CORE;
          cnt_d      = rst_ctrl_pkg::PULSE_CNT_LOAD;
        end
      end
      rst_ctrl_pkg::ST_HOLD: begin
        if (hw_active) begin
          start_chip = (scope_q != rst_ctrl_pkg::SCOPE_CHIP) || (|hw_rise);
          scope_d    = rst_ctrl_pkg::SCOPE_CHIP;
          cnt_d      = rst_ctrl_pkg::PULSE_CNT_LOAD;
        end else if (cnt_q == rst_ctrl_pkg::PULSE_CNT_W'(1)) begin
          state_d = rst_ctrl_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = rst_ctrl_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rst_ctrl_pkg::ST_IDLE;
      scope_q <= rst_ctrl_pkg::SCOPE_CORE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      scope_q <= scope_d;
      cnt_q   <= cnt_d;
    end
  end

  // Reset outputs, nested: chip implies system implies core
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset_o   <= 1'b1;
      system_reset_o <= 1'b1;
      core_reset_o   <= 1'b1;
    end else begin
      chip_reset_o   <= chip_hold(state_d, scope_d);
      system_reset_o <= (state_d == rst_ctrl_pkg::ST_HOLD) && (scope_d != rst_ctrl_pkg::SCOPE_CORE);
      core_reset_o   <= (state_d == rst_ctrl_pkg::ST_HOLD);
    end
  end

  always_comb begin
    cause_set                          = '0;
    cause_set[rst_ctrl_pkg::CAUSE_POR] = hw_rise[0];
    cause_set[rst_ctrl_pkg::CAUSE_PIN] = hw_rise[1];
    cause_set[rst_ctrl_pkg::CAUSE_WDT] = hw_rise[2];
    cause_set[rst_ctrl_pkg::CAUSE_LVD] = hw_rise[3];
    cause_set[rst_ctrl_pkg::CAUSE_BOD] = hw_rise[4];
    cause_set[rst_ctrl_pkg::CAUSE_SYS] = start_sys;
    cause_set[rst_ctrl_pkg::CAUSE_CORE] = start_core;
    cause_set[rst_ctrl_pkg::CAUSE_CHIP] = start_chip && ctrl_q[rst_ctrl_pkg::CTRL_CHIP_BIT];
  end

  // write-one clear
  // Set beats clear so a cause landing in the clear cycle is kept
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reset_cause_flags_o <= rst_ctrl_pkg::CAUSE_RESET;
    end else begin
      reset_cause_flags_o <= (reset_cause_flags_o & ~(reset_cause_clr_i ? reset_cause_clr_mask_i : '0))
                             | cause_set;
    end
  end

  // Control readback shows pending one-shots
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset_control_o <= rst_ctrl_pkg::CTRL_RESET;
    end else begin
      chip_reset_control_o <= ctrl_q;
    end
  end

  // boot select retention
  // Only chip-scope resets restore the default; writes are ignored while chip reset holds
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      boot_source_select_o <= rst_ctrl_pkg::BOOT_SEL_RESET;
    end else if (chip_hold(state_d, scope_d)) begin
      boot_source_select_o <= rst_ctrl_pkg::BOOT_SEL_RESET;
    end else if (boot_source_select_wr_i) begin
      boot_source_select_o <= boot_source_select_wdata_i;
    end
  end

endmodule

`default_nettype wire

//--- hdl/rst_ctrl_pkg.sv
package rst_ctrl_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS       = 25;
  localparam int unsigned RESET_PULSE_TIME_NS = 1000;
  localparam int unsigned RESET_PULSE_CYCLES  = (RESET_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W         = 6;
  localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_LOAD = PULSE_CNT_W'(RESET_PULSE_CYCLES);

  // External pin filter: low time in RC oscillator cycles
  localparam int unsigned PIN_FILT_W = 10;
  localparam logic [PIN_FILT_W-1:0] PIN_LOW_RC_CYCLES = 10'h300;

  // Reset cause flag positions
  localparam int unsigned CAUSE_W        = 8;
  localparam int unsigned CAUSE_POR      = 0;
  localparam int unsigned CAUSE_PIN      = 1;
  localparam int unsigned CAUSE_WDT      = 2;
  localparam int unsigned CAUSE_LVD      = 3;
  localparam int unsigned CAUSE_BOD      = 4;
  localparam int unsigned CAUSE_SYS      = 5;
  localparam int unsigned CAUSE_CORE     = 6;
  localparam int unsigned CAUSE_CHIP     = 7;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 8'h00;

  // Chip reset control bit positions
  localparam int unsigned CTRL_W         = 2;
  localparam int unsigned CTRL_CHIP_BIT  = 0;
  localparam int unsigned CTRL_CORE_BIT  = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  // Boot source select value after a chip-level reset
  localparam logic BOOT_SEL_RESET = 1'b0;

  // Reset scope being driven
  typedef enum logic [1:0] {
    SCOPE_CORE = 2'h0,
    SCOPE_SYS  = 2'h1,
    SCOPE_CHIP = 2'h2
  } scope_e;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } seq_state_e;

endpackage

//--- hdl/reset_pin_filter.sv
`timescale 1ns/100ps
`default_nettype none

// Glitch filter for the external reset pin, counting RC oscillator ticks
module reset_pin_filter (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_ni,
  // Pin and RC tick
  input  wire logic rc_tick_i,
  input  wire logic pin_i,
  // Filtered reset level
  output logic      pin_reset_o
);

  logic [rst_ctrl_pkg::PIN_FILT_W-1:0] low_cnt_q;

  // count low RC ticks
  // A high pin restarts the count, so short low pulses never reach the limit
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      low_cnt_q <= '0;
    end else if (pin_i) begin
      low_cnt_q <= '0;
    end else if (rc_tick_i && (low_cnt_q != rst_ctrl_pkg::PIN_LOW_RC_CYCLES)) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      pin_reset_o <= 1'b0;
    end else begin
      pin_reset_o <= !pin_i && (low_cnt_q == rst_ctrl_pkg::PIN_LOW_RC_CYCLES);
    end
  end

endmodule

`default_nettype wire

//--- tb/rst_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none

// Port-level checks of the reset controller
module rst_ctrl_checker (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       resetn_i,
  // Sources and requests
  input wire logic       power_on_detect_i,
  input wire logic       external_reset_input_i,
  input wire logic       watchdog_timeout_i,
  input wire logic       low_voltage_detect_i,
  input wire logic       brownout_detect_i,
  input wire logic       system_reset_request_i,
  input wire logic       chip_reset_control_wr_i,
  input wire logic [1:0] chip_reset_control_wdata_i,
  input wire logic       reset_cause_clr_i,
  input wire logic [7:0] reset_cause_clr_mask_i,
  input wire logic       boot_source_select_wr_i,
  // Outputs
  input wire logic       chip_reset_o,
  input wire logic       system_reset_o,
  input wire logic       core_reset_o,
  input wire logic [7:0] reset_cause_flags_o,
  input wire logic [1:0] chip_reset_control_o,
  input wire logic       boot_source_select_o
);
  logic [7:0]  hw_src;
  logic        quiet;
  logic        armed_q;
  logic [15:0] hi_cnt_q;

  // Level sources and a calm state, so request latencies are exact
  assign hw_src = {3'h0, brownout_detect_i, low_voltage_detect_i, watchdog_timeout_i, 2'h0};
  assign quiet = !core_reset_o && hw_src == 8'h00 && !power_on_detect_i && external_reset_input_i
                 && chip_reset_control_o == 2'h0;

  // Pulse length; the pulse left over from the reset release is not armed
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_q  <= 1'b0;
      hi_cnt_q <= 16'h0000;
    end else begin
      armed_q  <= armed_q | !core_reset_o;
      hi_cnt_q <= core_reset_o ? hi_cnt_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_HW_RESET: assert property (
    hw_src != 8'h00 || power_on_detect_i |=> chip_reset_o && system_reset_o && core_reset_o)
    else $error("hardware source without chip reset");
  AST_HW_FLAGS: assert property (
    hw_src != 8'h00 |=> (reset_cause_flags_o & $past(hw_src)) == $past(hw_src))
    else $error("hardware source flag missing");
  AST_FLAG_KEEP: assert property (
    !reset_cause_clr_i |=> (reset_cause_flags_o & $past(reset_cause_flags_o)) == $past(reset_cause_flags_o))
    else $error("cause flag lost without clear");
  AST_FLAG_CLEAR: assert property (
    reset_cause_clr_i && quiet && !$past(system_reset_request_i) && !$past(chip_reset_control_wr_i)
    |=> (reset_cause_flags_o & $past(reset_cause_clr_mask_i)) == 8'h00)
    else $error("cause flag not cleared");
  AST_CHIP_ONESHOT: assert property (
    chip_reset_control_wr_i && chip_reset_control_wdata_i[0] && quiet
    && !$past(system_reset_request_i) && !$past(chip_reset_control_wr_i)
    |-> ##2 chip_reset_o && reset_cause_flags_o[7])
    else $error("chip one-shot not served");
  AST_CTRL_SELFCLR: assert property (
    chip_reset_control_o[0] |-> ##[1:60] !chip_reset_control_o[0])
    else $error("chip one-shot bit stuck");
  AST_SYS_REQ: assert property (
    system_reset_request_i && quiet && !$past(system_reset_request_i) && !$past(chip_reset_control_wr_i)
    |-> ##2 system_reset_o && !chip_reset_o && reset_cause_flags_o[5])
    else $error("system request not served");
  AST_CORE_REQ: assert property (
    chip_reset_control_wr_i && chip_reset_control_wdata_i == 2'h2 && quiet && !system_reset_request_i
    && !$past(system_reset_request_i) && !$past(chip_reset_control_wr_i)
    |-> ##2 core_reset_o && !system_reset_o && reset_cause_flags_o[6])
    else $error("core one-shot not served");
  AST_PULSE_LEN: assert property (
    $fell(core_reset_o) && armed_q |-> hi_cnt_q >= 16'h0028)
    else $error("reset pulse too short");
  AST_BOOT_KEEP: assert property (
    !boot_source_select_wr_i && !chip_reset_o ##1 !chip_reset_o |-> $stable(boot_source_select_o))
    else $error("boot select changed outside chip reset");

  // Main scenarios
  cover property (chip_reset_control_wr_i && chip_reset_control_wdata_i[0]);
  cover property ($fell(core_reset_o) && armed_q);
  cover property (reset_cause_clr_i && quiet);
endmodule

bind system_reset_controller rst_ctrl_checker rst_ctrl_checker_inst (.*);

`default_nettype wire

//--- tb/ext_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

// External reset circuit on a pulled-up pin, plus the free RC tick
module ext_pin_model (
  // Clock and command
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic [10:0] low_ticks_i,
  // Pin, tick and status
  output logic             pin_o,
  output logic             tick_o,
  output logic             busy_o
);
  logic [10:0] cnt;
  logic        go;

  initial begin
    pin_o  = 1'b1;
    tick_o = 1'b0;
    busy_o = 1'b0;
  end

  // Pin low for exactly the asked number of ticks; drives just off the edge
  always @(posedge clk_i) begin
    go = start_i && !busy_o;
    #1;
    tick_o = !tick_o;
    if (go) begin
      busy_o = 1'b1;
      cnt    = 11'h000;
    end
    if (busy_o && cnt == low_ticks_i) begin
      busy_o = 1'b0;
      pin_o  = 1'b1; // Released pin returns to the pull-up level
    end else if (busy_o) begin
      pin_o = 1'b0;
      cnt   = cnt + {10'h000, tick_o};
    end
  end
endmodule

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

// Self-checking bench for the reset controller
module tb;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  logic [3:0]      hw = 4'h0;
  logic            sreq = 1'b0;
  logic            cwr = 1'b0;
  logic            clr = 1'b0;
  logic            bwr = 1'b0;
  logic            bdat = 1'b0;
  logic            start = 1'b0;
  logic [1:0]      cdat = 2'h0;
  logic [7:0]      mask = 8'h00;
  logic [7:0]      acc = 8'h00;
  logic [10:0]     lowt = 11'h000;
  logic [7:0]      fb [4] = '{8'h01, 8'h04, 8'h08, 8'h10};
  wire logic       pin, tick, busy, chip, sys, core, boot;
  wire logic [1:0] ctrl;
  wire logic [7:0] flags;
  int              err_total = 0;
  int              tests_run = 0;
  int              n;

  always #12.5 clk = ~clk;

  ext_pin_model ext_pin_model_inst (.clk_i(clk), .start_i(start), .low_ticks_i(lowt),
    .pin_o(pin), .tick_o(tick), .busy_o(busy));

  system_reset_controller system_reset_controller_inst (.clk_i(clk), .resetn_i(rstn),
    .power_on_detect_i(hw[0]), .external_reset_input_i(pin), .rc_tick_i(tick),
    .watchdog_timeout_i(hw[1]), .low_voltage_detect_i(hw[2]), .brownout_detect_i(hw[3]),
    .system_reset_request_i(sreq), .chip_reset_control_wr_i(cwr), .chip_reset_control_wdata_i(cdat),
    .reset_cause_clr_i(clr), .reset_cause_clr_mask_i(mask), .boot_source_select_wr_i(bwr),
    .boot_source_select_wdata_i(bdat), .chip_reset_o(chip), .system_reset_o(sys), .core_reset_o(core),
    .reset_cause_flags_o(flags), .chip_reset_control_o(ctrl), .boot_source_select_o(boot));

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Counts cycles until chip reset (hi) or until all is idle; a hang ends the run
  task automatic wait_for(input logic hi, output int c);
    c = 0;
    while (hi ? chip !== 1'b1 : core !== 1'b0 || busy) begin
      c++;
      if (c > 32'hfa0) begin
        chk("timeout", 8'h00, 8'h01);
        end_sim();
      end
      step(1);
    end
  endtask

  task automatic cwrite(input logic [1:0] d);
    cwr = 1'b1;
    cdat = d;
    step(1);
    cwr = 1'b0;
  endtask

  task automatic clear(input logic [7:0] m);
    clr = 1'b1;
    mask = m;
    step(1);
    clr = 1'b0;
    step(1);
  endtask

  initial begin
    step(5);
    rstn = 1'b1;
    step(6);
    chk("flags rst", 8'h00, flags);
    chk("boot rst", 8'h00, boot);
    // Pin low one tick short, then long enough
    lowt = 11'h2ff;
    start = 1'b1;
    step(1);
    start = 1'b0;
    wait_for(1'b0, n);
    chk("pin short", 8'h00, flags);
    lowt = 11'h320;
    start = 1'b1;
    step(1);
    start = 1'b0;
    wait_for(1'b1, n);
    chk("pin late", 8'h01, {7'h00, n >= 32'h5fa});
    chk("pin flag", 8'h02, flags);
    wait_for(1'b0, n);
    clear(8'hff);
    chk("clear all", 8'h00, flags);
    // Each level source in turn, flags accumulating
    for (int i = 0; i < 4; i++) begin
      hw[i] = 1'b1;
      step(1);
      hw[i] = 1'b0;
      step(1);
      chk("hw chip", 8'h01, chip);
      wait_for(1'b0, n);
      acc = acc | fb[i];
      chk("hw flags", acc, flags);
    end
    clear(8'h04);
    chk("clear wdt", 8'h19, flags);
    clear(8'hff);
    // Boot select across system, core and chip scopes
    bwr = 1'b1;
    bdat = 1'b1;
    step(1);
    bwr = 1'b0;
    chk("boot wr", 8'h01, boot);
    sreq = 1'b1;
    step(1);
    sreq = 1'b0;
    step(1);
    chk("sys scope", 8'h03, {chip, sys, core});
    wait_for(1'b0, n);
    chk("sys len", 8'h28, n[7:0]);
    chk("sys flag", 8'h20, flags);
    chk("boot sys", 8'h01, boot);
    cwrite(2'h2);
    step(1);
    chk("core scope", 8'h01, {chip, sys, core});
    wait_for(1'b0, n);
    chk("core flag", 8'h60, flags);
    chk("boot core", 8'h01, boot);
    cwrite(2'h1);
    step(1);
    chk("ctrl pend", 8'h01, ctrl);
    chk("chip scope", 8'h07, {chip, sys, core});
    step(1);
    chk("ctrl clr", 8'h00, ctrl);
    wait_for(1'b0, n);
    chk("chip len", 8'h27, n[7:0]);
    chk("chip flag", 8'he0, flags);
    chk("boot chip", 8'h00, boot);
    clear(8'h20);
    chk("clear sys", 8'hc0, flags);
    end_sim();
  end
endmodule

`default_nettype wire
